// ==== hdl/sfsp_regs.svh ====
// constants for the serial nonvolatile ram command front end
// assumes inclusion by bare name from the core and its helpers
`ifndef SFSP_REGS_SVH
`define SFSP_REGS_SVH

// op-code values
`define SFSP_OP_SET_LATCH 8'h06
`define SFSP_OP_CLR_LATCH 8'h04
`define SFSP_OP_STAT_RD 8'h05
`define SFSP_OP_STAT_WR 8'h01
`define SFSP_OP_MEM_RD 8'h03
`define SFSP_OP_MEM_WR 8'h02

// status byte field positions
`define SFSP_BIT_ARM 7
`define SFSP_BIT_BG_HI 3
`define SFSP_BIT_BG_LO 2
`define SFSP_BIT_LATCH 1

// reset values
`define SFSP_ARM_RST 1'h0
`define SFSP_BG_RST 2'h0
`define SFSP_LATCH_RST 1'h0

// block guard thresholds and array geometry
`define SFSP_GUARD_QTR 13'h1800
`define SFSP_GUARD_HALF 13'h1000
`define SFSP_MEM_WORDS 8192

// serial framing counts
`define SFSP_BIT_LAST 3'h7
`define SFSP_BYTE_OP 2'h0
`define SFSP_BYTE_A_HI 2'h1
`define SFSP_BYTE_A_LO 2'h2
`define SFSP_BYTE_DATA 2'h3

// event toggles crossing from link to system clock
`define SFSP_EV_SET 0
`define SFSP_EV_CLR 1
`define SFSP_EV_WCMD 2
`define SFSP_EV_SWR 3
`define SFSP_EV_COUNT 4

`endif

// ==== hdl/sfsp_pkg.sv ====
// types shared by the command front end and its helpers
// assumes nothing beyond a SystemVerilog compiler
package sfsp_pkg;

  typedef enum logic [2:0] {
    cmd_idle = 3'b000,
    set_write_latch_cmd = 3'b001,
    clear_write_latch_cmd = 3'b010,
    status_read_cmd = 3'b011,
    status_write_cmd = 3'b100,
    mem_read_cmd = 3'b101,
    mem_write_cmd = 3'b110,
    cmd_ignore = 3'b111
  } sfsp_cmd_t;

  // link state that lives only for one select frame
  typedef struct packed {
    logic [2:0] bitcnt;
    logic [1:0] bytecnt;
    sfsp_cmd_t cmd;
    logic [6:0] sh;
    logic [12:0] addr;
  } sfsp_frame_t;

  // link state that outlives a frame
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] tog;
    logic [7:0] swr_data;
  } sfsp_keep_t;

  // falling edge output stage
  typedef struct packed {
    logic so;
    logic oe;
    logic [6:0] osh;
  } sfsp_drive_t;

  // system clock state
  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs_prev;
    logic wp1;
    logic wp2;
    logic md1;
    logic md2;
    logic latch;
    logic arm;
    logic [1:0] bg;
    logic wr_pend;
    logic [7:0] status_byte;
    logic frame_active;
    logic link_mode3;
  } sfsp_sys_t;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
  } sfsp_tsync_t;

endpackage : sfsp_pkg

// ==== hdl/sfsp_evt_sync.sv ====
// toggle to pulse synchroniser into the system clock
// assumes the toggle changes at most once per three system clocks
`timescale 1ns/100ps
module sfsp_evt_sync (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // toggle from the link clock
  input wire logic tog_in,
  // one cycle pulse per toggle
  output logic pulse
);
  import sfsp_pkg::*;

  sfsp_tsync_t st;
  sfsp_tsync_t next_st;

  always_comb begin
    next_st = st;
    next_st.f1 = tog_in;
    next_st.f2 = st.f1;
    next_st.f3 = st.f2;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // f1 feeds only f2; the edge is seen between f2 and f3
  assign pulse = st.f2 ^ st.f3;

endmodule : sfsp_evt_sync

// ==== hdl/sfsp_core.sv ====
// command front end of a serial nonvolatile ram with write protection
// assumes a host bus master in clock mode 0 or 3; sck is the link clock,
// clk_sys the system clock; pins are unrelated to clk_sys
`timescale 1ns/100ps
`include "sfsp_regs.svh"

// Overview of operation
// R1: modes 0 and 3, sensed at select fall
// R2: master drops idle-high clock before first bit
// R3: sample on rising, drive on falling
// R4: whole bytes, most significant bit first
// R5: first byte of frame is op-code
// R6: one command per select frame
// R7: decode set and clear latch op-codes
// R8: decode status read and status write
// R9: decode memory read and memory write
// R10: latch cleared at power-up
// R11: set command sets latch, shown in status
// R12: status write never alters latch flag
// R13: latch clears when write frame ends
// R14: clear command resets latch
// R15: status read shifts out status byte
// R16: master enables latch and raises protect pin
// R17: status bit layout, unused bits zero
// R18: guard and arm bits kept, latch volatile; here arm and guard also restart at nrst
// R19: block guard ranges block memory writes
// R20: armed low protect pin blocks status write
// R21: protect pin never blocks array writes
// R22: select high: output released, inputs ignored
// R23: thirteen bit address, increments and wraps
// R24: each data byte committed after eighth clock
// R25: unknown op-code ignored until select rises
module sfsp_core (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  // status view for the system
  output logic [7:0] status_byte,
  output logic frame_active,
  output logic link_mode3
);
  import sfsp_pkg::*;

  // op-code lookup, unknown values map to the ignore state
  function automatic sfsp_cmd_t decode_op(input logic [7:0] op);
    sfsp_cmd_t c;
    c = cmd_ignore;
    case (op)
      `SFSP_OP_SET_LATCH: c = set_write_latch_cmd; // [R7]
      `SFSP_OP_CLR_LATCH: c = clear_write_latch_cmd; // [R7]
      `SFSP_OP_STAT_RD: c = status_read_cmd; // [R8]
      `SFSP_OP_STAT_WR: c = status_write_cmd; // [R8]
      `SFSP_OP_MEM_RD: c = mem_read_cmd; // [R9]
      `SFSP_OP_MEM_WR: c = mem_write_cmd; // [R9]
      default: c = cmd_ignore; // [R25]
    endcase
    return c;
  endfunction : decode_op

  // protected address ranges per guard setting
  function automatic logic guarded(input logic [12:0] a, input logic [1:0] bg);
    logic hit;
    hit = 1'b0;
    if (bg == 2'h1) begin
      hit = (a >= `SFSP_GUARD_QTR); // [R19]
    end else if (bg == 2'h2) begin
      hit = (a >= `SFSP_GUARD_HALF); // [R19]
    end else if (bg == 2'h3) begin
      hit = 1'b1; // [R19]
    end
    return hit;
  endfunction : guarded

  // status byte assembly, unused positions stay zero
  function automatic logic [7:0] status_pack(
    input logic latch,
    input logic arm,
    input logic [1:0] bg
  );
    logic [7:0] s;
    s = 8'h00; // [R17]
    s[`SFSP_BIT_ARM] = arm;
    s[`SFSP_BIT_BG_HI] = bg[1];
    s[`SFSP_BIT_BG_LO] = bg[0];
    s[`SFSP_BIT_LATCH] = latch; // [R11]
    return s;
  endfunction : status_pack

  sfsp_frame_t fr;
  sfsp_frame_t next_fr;
  sfsp_keep_t kp;
  sfsp_keep_t next_kp;
  sfsp_drive_t dr;
  sfsp_drive_t next_dr;
  sfsp_sys_t sy;
  sfsp_sys_t next_sy;

  logic [7:0] mem [0:`SFSP_MEM_WORDS-1];
  logic mem_we;
  logic [7:0] in_byte;
  logic byte_done;
  logic frame_rst_n;
  logic mode3_cap;
  logic [`SFSP_EV_COUNT-1:0] ev;
  logic [7:0] link_status;

  // select high holds the frame logic in reset; sck may stop outside frames
  assign frame_rst_n = nrst & ~cs_n; // [R22]

  // clock level at select fall tells mode 3 (high) from mode 0 (low)
  always_ff @(negedge cs_n or negedge nrst) begin
    if (!nrst) begin
      mode3_cap <= 1'b0;
    end else begin
      mode3_cap <= sck; // [R1]
    end
  end

  // status as seen from the link clock, through a two flop synchroniser
  assign link_status = status_pack(kp.sync2[3], kp.sync2[2], kp.sync2[1:0]);

  // rising edge: shift in, count, decode
  always_comb begin
    next_fr = fr;
    next_kp = kp;
    mem_we = 1'b0;
    in_byte = {fr.sh, si}; // [R4]
    byte_done = (fr.bitcnt == `SFSP_BIT_LAST); // [R4]
    // refreshed on the op-code clocks, settled before any byte needs them
    next_kp.sync1 = {sy.latch, sy.arm, sy.bg};
    next_kp.sync2 = kp.sync1;
    next_fr.sh = in_byte[6:0]; // [R3]
    next_fr.bitcnt = fr.bitcnt + 3'h1;
    if (byte_done) begin
      if (fr.bytecnt != `SFSP_BYTE_DATA) begin
        next_fr.bytecnt = fr.bytecnt + 2'h1;
      end
      case (fr.cmd)
        cmd_idle: begin
          // only the first byte of a frame is decoded
          next_fr.cmd = decode_op(in_byte); // [R5] [R6]
          case (decode_op(in_byte))
            set_write_latch_cmd: begin
              next_kp.tog[`SFSP_EV_SET] = ~kp.tog[`SFSP_EV_SET]; // [R11]
            end
            clear_write_latch_cmd: begin
              next_kp.tog[`SFSP_EV_CLR] = ~kp.tog[`SFSP_EV_CLR]; // [R14]
            end
            status_write_cmd, mem_write_cmd: begin
              next_kp.tog[`SFSP_EV_WCMD] = ~kp.tog[`SFSP_EV_WCMD]; // [R13]
            end
            default: begin
            end
          endcase
        end
        status_write_cmd: begin
          // exactly one data byte; any further bytes fall on the floor
          if (fr.bytecnt == `SFSP_BYTE_A_HI) begin
            next_kp.swr_data = in_byte; // [R8]
            next_kp.tog[`SFSP_EV_SWR] = ~kp.tog[`SFSP_EV_SWR];
          end
        end
        mem_read_cmd, mem_write_cmd: begin
          if (fr.bytecnt == `SFSP_BYTE_A_HI) begin
            next_fr.addr[12:8] = in_byte[4:0]; // [R23]
          end else if (fr.bytecnt == `SFSP_BYTE_A_LO) begin
            next_fr.addr[7:0] = in_byte; // [R23]
          end else begin
            // the protect pin plays no part here
            if (fr.cmd == mem_write_cmd && kp.sync2[3]
                && !guarded(fr.addr, kp.sync2[1:0])) begin // [R19] [R21]
              mem_we = 1'b1; // [R24]
            end
            next_fr.addr = fr.addr + 13'h0001; // [R23]
          end
        end
        default: begin
          // set, clear, status read and unknown codes take no more bytes
        end
      endcase
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr <= '{bitcnt: 3'h0, bytecnt: `SFSP_BYTE_OP, cmd: cmd_idle,
              sh: 7'h00, addr: 13'h0000}; // [R22]
    end else begin
      fr <= next_fr; // [R3]
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      kp <= '0;
    end else begin
      kp <= next_kp;
    end
  end

  // array write lands on the same edge that completes the byte
  always_ff @(posedge sck) begin
    if (mem_we) begin
      mem[fr.addr] <= in_byte; // [R24]
    end
  end

  // falling edge: output shifter, loads at the status read and memory read data byte boundaries
  always_comb begin
    next_dr = dr;
    if (dr.oe) begin
      next_dr.so = dr.osh[6]; // [R4]
      next_dr.osh = {dr.osh[5:0], 1'b0};
    end
    // mode 3 gives one falling edge before any data; bitcnt 0 and op byte
    if (fr.bitcnt == 3'h0) begin
      if (fr.cmd == status_read_cmd && fr.bytecnt == `SFSP_BYTE_A_HI) begin
        next_dr.so = link_status[7]; // [R15]
        next_dr.osh = link_status[6:0];
        next_dr.oe = 1'b1;
      end else if (fr.cmd == mem_read_cmd && fr.bytecnt == `SFSP_BYTE_DATA) begin
        next_dr.so = mem[fr.addr][7]; // [R9]
        next_dr.osh = mem[fr.addr][6:0];
        next_dr.oe = 1'b1;
      end else begin
        next_dr.oe = 1'b0; // [R25]
      end
    end
  end

  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      dr <= '0; // [R22]
    end else begin
      dr <= next_dr; // [R3]
    end
  end

  assign so = dr.so;
  assign so_oe = dr.oe;

  // link events become one cycle pulses on the system clock
  for (genvar i = 0; i < `SFSP_EV_COUNT; i++) begin : g_ev
    sfsp_evt_sync u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .tog_in(kp.tog[i]),
      .pulse(ev[i])
    );
  end

  // system clock: latch and protection bits
  always_comb begin
    next_sy = sy;
    next_sy.cs1 = cs_n;
    next_sy.cs2 = sy.cs1;
    next_sy.wp1 = wp_n;
    next_sy.wp2 = sy.wp1;
    next_sy.md1 = mode3_cap;
    next_sy.md2 = sy.md1;
    next_sy.cs_prev = sy.cs2;
    if (sy.cs2 && !sy.cs_prev && sy.wr_pend) begin
      next_sy.latch = 1'b0; // [R13]
      next_sy.wr_pend = 1'b0;
    end
    if (ev[`SFSP_EV_WCMD]) begin
      next_sy.wr_pend = 1'b1; // [R13]
    end
    if (ev[`SFSP_EV_CLR]) begin
      next_sy.latch = 1'b0; // [R14]
    end
    // set after clear so a set arriving with a clear is kept
    if (ev[`SFSP_EV_SET]) begin
      next_sy.latch = 1'b1; // [R11]
    end
    // swr_data is held still from its toggle until the next status frame
    if (ev[`SFSP_EV_SWR] && sy.latch && !(sy.arm && !sy.wp2)) begin // [R20]
      next_sy.arm = kp.swr_data[`SFSP_BIT_ARM]; // [R17]
      next_sy.bg[1] = kp.swr_data[`SFSP_BIT_BG_HI];
      next_sy.bg[0] = kp.swr_data[`SFSP_BIT_BG_LO]; // [R12]
    end
    next_sy.status_byte = status_pack(next_sy.latch, next_sy.arm, next_sy.bg);
    next_sy.frame_active = ~sy.cs2;
    next_sy.link_mode3 = sy.md2; // [R1]
  end

  // arm and guard model storage without power; here they restart at reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sy <= '{cs1: 1'b1, cs2: 1'b1, cs_prev: 1'b1, wp1: 1'b1, wp2: 1'b1,
              md1: 1'b0, md2: 1'b0, latch: `SFSP_LATCH_RST, arm: `SFSP_ARM_RST,
              bg: `SFSP_BG_RST, wr_pend: 1'b0, status_byte: 8'h00,
              frame_active: 1'b0, link_mode3: 1'b0}; // [R10] [R18]
    end else begin
      sy <= next_sy;
    end
  end

  assign status_byte = sy.status_byte;
  assign frame_active = sy.frame_active;
  assign link_mode3 = sy.link_mode3;

endmodule : sfsp_core

// ==== testbench/sfsp_core_sva.sv ====
// checker for the command front end, system clock view of its pins
// assumes pins settle between system clock edges
`timescale 1ns/100ps
module sfsp_core_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // link pins
  input wire logic cs_n,
  input wire logic wp_n,
  input wire logic so_oe,
  // status view
  input wire logic [7:0] status_byte,
  input wire logic frame_active,
  input wire logic link_mode3
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_sel_on;
    !cs_n [*5];
  endsequence
  sequence s_sel_off;
    cs_n [*5];
  endsequence
  property p_idle_release;
    cs_n |-> !so_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("output driven while idle");
  property p_fixed_bits;
    status_byte[6:4] == 3'h0 && !status_byte[0];
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits not zero");
  property p_reset_clear;
    $rose(nrst) |-> status_byte == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("status not clear after reset");
  property p_need_latch;
    $changed(status_byte[7:2]) |-> $past(status_byte[1]);
  endproperty
  a_need_latch: assert property (p_need_latch) else $error("status changed without latch");
  property p_pin_guard;
    $changed(status_byte[7:2]) |-> !$past(status_byte[7]) || $past(wp_n);
  endproperty
  a_pin_guard: assert property (p_pin_guard) else $error("status changed while pin guarded");
  property p_frame_on;
    s_sel_on |-> frame_active;
  endproperty
  a_frame_on: assert property (p_frame_on) else $error("frame not seen");
  property p_frame_off;
    s_sel_off |-> !frame_active;
  endproperty
  a_frame_off: assert property (p_frame_off) else $error("frame seen while idle");
  property p_mode_hold;
    frame_active [*8] |-> $stable(link_mode3);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed inside frame");
endmodule : sfsp_core_sva

bind sfsp_core sfsp_core_sva i_sva (.clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .wp_n(wp_n),
  .so_oe(so_oe), .status_byte(status_byte), .frame_active(frame_active),
  .link_mode3(link_mode3));

// ==== testbench/sfsp_host_model.sv ====
// host bus master model driving select, clock and serial input
// assumes caller sequences start, bytes and stop
`timescale 1ns/100ps
module sfsp_host_model (
  // link pins
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic line;
  logic mode;
  logic oe_seen;
  // released output shows no stale level
  assign line = so_oe ? so : ~so;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    mode = 1'b0;
    oe_seen = 1'b0;
  end
  always @(posedge so_oe) oe_seen = 1'b1;
  task automatic start(input logic m);
    mode = m;
    oe_seen = 1'b0;
    sck = m;
    #103 cs_n = 1'b0;
    #40 sck = 1'b0;
  endtask : start
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      #40 sck = 1'b1;
      rx[i] = line;
      #40 sck = 1'b0;
    end
  endtask : xbyte
  // select rises before the clock returns to its idle level, so mode 3 adds no ninth edge
  task automatic stop();
    #40 cs_n = 1'b1;
    #40 sck = mode;
    si = ~si;
    #200;
  endtask : stop
endmodule : sfsp_host_model

// ==== testbench/serial_fram_spi_protect_tb.sv ====
// self-checking bench for the command front end
// assumes the host model drives the link with its own clock
`timescale 1ns/100ps
module serial_fram_spi_protect_tb;
  import sfsp_pkg::*;
  logic clk_sys, nrst, wp_n, cs_n, sck, si, so, so_oe, frame_active, link_mode3;
  logic [7:0] status_byte;
  logic [7:0] rx[$];
  int bad_count = 0;
  int n_checks = 0;
  sfsp_core i_dut (.clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .status_byte(status_byte),
    .frame_active(frame_active), .link_mode3(link_mode3));
  sfsp_host_model i_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic frame(input logic m, input logic [7:0] tx[$]);
    logic [7:0] b;
    rx = {};
    i_host.start(m);
    foreach (tx[i]) begin
      i_host.xbyte(tx[i], b);
      rx.push_back(b);
    end
    i_host.stop();
  endtask : frame
  task automatic set_wp(input logic v);
    @(posedge clk_sys);
    #1 wp_n = v;
  endtask : set_wp
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic t_latch();
    frame(1'b0, '{8'h06});
    chk(status_byte, 8'h02);
    frame(1'b1, '{8'h05, 8'h00});
    chk(rx[1], 8'h02);
    chk({7'h00, link_mode3}, 8'h01);
    frame(1'b0, '{8'h04});
    frame(1'b0, '{8'h05, 8'h00});
    chk(rx[1], 8'h00);
    chk({7'h00, link_mode3}, 8'h00);
  endtask : t_latch
  task automatic t_mem_fill();
    frame(1'b0, '{8'h06});
    frame(1'b0, '{8'h02, 8'h17, 8'hFF, 8'h11, 8'h22});
    chk(status_byte, 8'h00);
  endtask : t_mem_fill
  task automatic t_status();
    frame(1'b0, '{8'h01, 8'h8C});
    chk(status_byte, 8'h00);
    frame(1'b0, '{8'h06});
    frame(1'b1, '{8'h01, 8'hF7});
    chk(status_byte, 8'h84);
    set_wp(1'b0);
    frame(1'b0, '{8'h06});
    frame(1'b0, '{8'h01, 8'h00});
    chk(status_byte, 8'h84);
  endtask : t_status
  task automatic t_guard();
    frame(1'b0, '{8'h06});
    frame(1'b0, '{8'hAA, 8'h05, 8'h00});
    chk({7'h00, i_host.oe_seen}, 8'h00);
    chk(status_byte, 8'h86);
    frame(1'b0, '{8'h02, 8'h37, 8'hFF, 8'h33, 8'h44});
    frame(1'b0, '{8'h03, 8'h17, 8'hFF, 8'h00, 8'h00});
    chk(rx[3], 8'h33);
    chk(rx[4], 8'h22);
  endtask : t_guard
  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(status_byte, 8'h00);
    t_latch();
    t_mem_fill();
    t_status();
    t_guard();
    test_done();
  end
  // whole run is near 28 us of link traffic
  initial begin
    #150000;
    bad_count++;
    test_done();
  end
endmodule : serial_fram_spi_protect_tb
